// *** rtl/sgc_consts.svh ***
// register offsets, field positions, reset values and timing counts for the sound generator
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH
`define SGC_OFS_CLK 4'h0
`define SGC_OFS_SEL 4'h2
`define SGC_OFS_CTL 4'h4
`define SGC_OFS_DAT 4'h6
`define SGC_OFS_INTF 4'h8
`define SGC_OFS_INTE 4'ha
`define SGC_CLK_DEBUG_RUN 8
`define SGC_CTL_STOP 8
`define SGC_CTL_EN 0
`define SGC_SEL_DRV 2
`define SGC_INTF_BUSY 8
`define SGC_INTF_EMPTY 1
`define SGC_INTF_DONE 0
`define SGC_DAT_RESET 16'h00ff
`define SGC_DIV_DIRECT 3'h7
`define SGC_DIV_MAX 3'h5
// base tick of 1/32768 s expressed in core cycles at 50 MHz (rounded down)
`define SGC_TICK_NS 30518
`define SGC_CLK_NS 20
`define SGC_TICK_CYC ((`SGC_TICK_NS) / (`SGC_CLK_NS))
// one-shot duration only: 512 ticks per step of the timing field
`define SGC_STEP_TICKS 512
`endif

// *** rtl/sgc_pkg.sv ***
// types shared by the sound generator control modules
package sgc_pkg;
   typedef enum logic [1:0] {
      SGC_SRC_INTERNAL = 2'h0,
      SGC_SRC_LSX = 2'h1,
      SGC_SRC_HSO = 2'h2,
      SGC_SRC_EXT = 2'h3
   } sgc_src_t;
   typedef enum logic [1:0] {
      SGC_MODE_NORMAL = 2'h0,
      SGC_MODE_ONESHOT = 2'h1,
      SGC_MODE_MELODY = 2'h2,
      SGC_MODE_RSVD = 2'h3
   } sgc_mode_t;
   typedef enum logic [1:0] {
      SGC_IDLE,
      SGC_PLAY,
      SGC_STOPPING
   } sgc_state_t;
endpackage

// *** rtl/sgc_tick_if.sv ***
// clock-enable bundle between the divider and the sequencer
`timescale 1ns/1ns
interface sgc_tick_if;
   logic tick;
   logic run;
   modport src (output tick, input run);
   modport dst (input tick, output run);
endinterface

// *** rtl/sgc_clkdiv.sv ***
// operating-clock enable: source tick divided per source and divide select
`timescale 1ns/1ns
`include "sgc_consts.svh"
module sgc_clkdiv (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [1:0] src_sel,
   input wire logic [2:0] div_sel,
   sgc_tick_if.src tk
);
   logic [15:0] base_r, base_nxt;
   logic [6:0] div_r, div_nxt;
   logic tick_r, tick_nxt;
   logic base_hit;
   logic direct;

   // divide code to terminal count of the 1/4..1/128 prescaler
   function automatic logic [6:0] div_limit(input logic [2:0] code);
      logic [7:0] v;
      v = 8'h04 << code;
      div_limit = v[6:0] - 7'h01;
   endfunction

   // slow sources use code 0x7 as 1/1; fast sources sub-divide
   assign direct = (src_sel == 2'h1) || (src_sel == 2'h3);
   assign base_hit = (base_r == 16'((`SGC_TICK_CYC) - 1));

   always_comb begin
      base_nxt = base_r;
      div_nxt = div_r;
      tick_nxt = 1'b0;
      if (tk.run) begin
         base_nxt = base_hit ? 16'h0000 : base_r + 16'h0001;
         if (base_hit) begin
            if (direct) begin
               tick_nxt = (div_sel == `SGC_DIV_DIRECT);
            end else if (div_sel <= `SGC_DIV_MAX) begin
               div_nxt = (div_r >= div_limit(div_sel)) ? 7'h00 : div_r + 7'h01;
               tick_nxt = (div_r >= div_limit(div_sel));
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         base_r <= 16'h0000;
         div_r <= 7'h00;
         tick_r <= 1'b0;
      end else begin
         base_r <= base_nxt;
         div_r <= div_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tk.tick = tick_r;
endmodule

// *** rtl/sgc_tone.sv ***
// square-wave tone from period and high-length fields, paced by the operating tick
`timescale 1ns/1ns
module sgc_tone (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic active,
   input wire logic rest,
   input wire logic [7:0] period,
   input wire logic [5:0] high_len,
   output logic wave
);
   logic [7:0] cnt_r, cnt_nxt;
   logic wave_r, wave_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      wave_nxt = wave_r;
      if (!active) begin
         cnt_nxt = 8'h00;
         wave_nxt = 1'b0;
      end else if (tick) begin
         cnt_nxt = (cnt_r >= period) ? 8'h00 : cnt_r + 8'h01;
         // rest keeps the line low for the whole note
         wave_nxt = !rest && (cnt_r < {2'b00, high_len});
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_r <= 8'h00;
         wave_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         wave_r <= wave_nxt;
      end
   end

   assign wave = wave_r;
endmodule

// *** rtl/sgc_top.sv ***
// sound generator control: registers, sequencing, flags and interrupt request
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "sgc_consts.svh"
module sgc_top (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic full_word,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic debug_mode,
   output logic tone_out,
   output logic tone_out_n,
   output logic irq
);
   sgc_tick_if tk ();

   // configuration registers
   logic dbg_run_r, dbg_run_nxt;
   logic [2:0] div_r, div_nxt;
   logic [1:0] src_r, src_nxt;
   logic [3:0] tempo_r, tempo_nxt;
   logic drive_r, drive_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic en_r, en_nxt;
   logic [1:0] ie_r, ie_nxt;
   logic [15:0] buf_r, buf_nxt;
   // sequencing state
   sgc_pkg::sgc_state_t st_r, st_nxt;
   logic [15:0] snd_r, snd_nxt;
   logic full_r, full_nxt;
   logic empty_r, empty_nxt;
   logic done_r, done_nxt;
   logic stop_r, stop_nxt;
   logic [13:0] len_r, len_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic wave;
   logic busy;
   logic wr_clk, wr_sel, wr_ctl, wr_dat, wr_intf, wr_inte;
   logic stop_wr;
   logic expire;
   logic [14:0] span;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = wr && (a == ofs);
   endfunction

   assign wr_clk = hit(addr, `SGC_OFS_CLK);
   assign wr_sel = hit(addr, `SGC_OFS_SEL);
   assign wr_ctl = hit(addr, `SGC_OFS_CTL);
   assign wr_dat = hit(addr, `SGC_OFS_DAT) && full_word;
   assign wr_intf = hit(addr, `SGC_OFS_INTF);
   assign wr_inte = hit(addr, `SGC_OFS_INTE);
   assign stop_wr = wr_ctl && wdata[`SGC_CTL_STOP] && en_r;

   assign tk.run = en_r && (!debug_mode || dbg_run_r);
   assign busy = (st_r != sgc_pkg::SGC_IDLE);

   // one-shot: (field+1) steps; melody: note length scaled by tempo
   always_comb begin
      span = 15'({tempo_r, 9'h000}) + 15'(`SGC_STEP_TICKS);
      if (mode_r == sgc_pkg::SGC_MODE_MELODY) begin
         // 15 bits: longest note times slowest tempo is exactly 2^14 ticks
         span = (({9'h000, snd_r[13:8]} + 15'h0001) * ({11'h000, tempo_r} + 15'h0001)) << 4;
      end
   end
   assign expire = tk.tick && ({1'b0, len_r} >= span - 15'h0001);

   always_comb begin
      dbg_run_nxt = dbg_run_r;
      div_nxt = div_r;
      src_nxt = src_r;
      tempo_nxt = tempo_r;
      drive_nxt = drive_r;
      mode_nxt = mode_r;
      en_nxt = en_r;
      ie_nxt = ie_r;
      if (wr_clk && !en_r) begin
         dbg_run_nxt = wdata[`SGC_CLK_DEBUG_RUN];
         div_nxt = wdata[6:4];
         src_nxt = wdata[1:0];
      end
      if (wr_sel) begin
         // timing field stability while busy is left to software
         tempo_nxt = wdata[11:8];
         drive_nxt = wdata[`SGC_SEL_DRV];
         mode_nxt = wdata[1:0];
      end
      if (wr_ctl) begin
         en_nxt = wdata[`SGC_CTL_EN];
      end
      if (wr_inte) begin
         ie_nxt = wdata[1:0];
      end
   end

   always_comb begin
      st_nxt = st_r;
      buf_nxt = buf_r;
      snd_nxt = snd_r;
      full_nxt = full_r;
      empty_nxt = empty_r;
      done_nxt = done_r;
      stop_nxt = stop_r;
      len_nxt = len_r;
      if (wr_dat) begin
         buf_nxt = wdata;
         full_nxt = 1'b1;
         empty_nxt = 1'b0;
         done_nxt = 1'b0;
      end
      if (wr_intf && wdata[`SGC_INTF_DONE]) begin
         done_nxt = 1'b0;
      end
      if (stop_wr && busy) begin
         stop_nxt = 1'b1;
         empty_nxt = 1'b1;
         full_nxt = 1'b0;
      end else if (stop_wr) begin
         empty_nxt = 1'b1;
         full_nxt = 1'b0;
      end
      if (!en_r) begin
         st_nxt = sgc_pkg::SGC_IDLE;
         stop_nxt = 1'b0;
         len_nxt = 14'h0000;
      end else if (tk.tick) begin
         unique case (st_r)
            sgc_pkg::SGC_IDLE: begin
               if (full_r && mode_r != sgc_pkg::SGC_MODE_RSVD && !stop_r) begin
                  snd_nxt = buf_r;
                  full_nxt = wr_dat;
                  empty_nxt = !wr_dat;
                  len_nxt = 14'h0000;
                  st_nxt = sgc_pkg::SGC_PLAY;
               end
            end
            sgc_pkg::SGC_PLAY: begin
               len_nxt = len_r + 14'h0001;
               if (stop_r) begin
                  st_nxt = sgc_pkg::SGC_IDLE;
                  stop_nxt = 1'b0;
                  done_nxt = 1'b1;
               end else if (mode_r != sgc_pkg::SGC_MODE_NORMAL && expire) begin
                  if (mode_r == sgc_pkg::SGC_MODE_MELODY && full_r) begin
                     snd_nxt = buf_r;
                     full_nxt = wr_dat;
                     empty_nxt = !wr_dat;
                     len_nxt = 14'h0000;
                  end else begin
                     st_nxt = sgc_pkg::SGC_IDLE;
                     done_nxt = 1'b1;
                  end
               end
            end
            sgc_pkg::SGC_STOPPING: begin
               st_nxt = sgc_pkg::SGC_IDLE;
               stop_nxt = 1'b0;
               done_nxt = 1'b1;
            end
         endcase
      end else if (st_r == sgc_pkg::SGC_IDLE) begin
         stop_nxt = 1'b0;
      end
   end

   always_comb begin
      rdata_nxt = 16'h0000;
      if (rd) begin
         unique case (addr)
            `SGC_OFS_CLK: rdata_nxt = {7'h00, dbg_run_r, 1'b0, div_r, 2'b00, src_r};
            `SGC_OFS_SEL: rdata_nxt = {4'h0, tempo_r, 5'h00, drive_r, mode_r};
            `SGC_OFS_CTL: rdata_nxt = {7'h00, stop_r, 7'h00, en_r};
            `SGC_OFS_DAT: rdata_nxt = buf_r;
            `SGC_OFS_INTF: rdata_nxt = {7'h00, busy, 6'h00, empty_r, done_r};
            `SGC_OFS_INTE: rdata_nxt = {14'h0000, ie_r};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dbg_run_r <= 1'b0;
         div_r <= 3'h0;
         src_r <= 2'h0;
         tempo_r <= 4'h0;
         drive_r <= 1'b0;
         mode_r <= 2'h0;
         en_r <= 1'b0;
         ie_r <= 2'h0;
         buf_r <= `SGC_DAT_RESET;
         st_r <= sgc_pkg::SGC_IDLE;
         snd_r <= `SGC_DAT_RESET;
         full_r <= 1'b0;
         empty_r <= 1'b1;
         done_r <= 1'b0;
         stop_r <= 1'b0;
         len_r <= 14'h0000;
         rdata_r <= 16'h0000;
      end else begin
         dbg_run_r <= dbg_run_nxt;
         div_r <= div_nxt;
         src_r <= src_nxt;
         tempo_r <= tempo_nxt;
         drive_r <= drive_nxt;
         mode_r <= mode_nxt;
         en_r <= en_nxt;
         ie_r <= ie_nxt;
         buf_r <= buf_nxt;
         st_r <= st_nxt;
         snd_r <= snd_nxt;
         full_r <= full_nxt;
         empty_r <= empty_nxt;
         done_r <= done_nxt;
         stop_r <= stop_nxt;
         len_r <= len_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   sgc_clkdiv u_div (
      .core_clk(core_clk),
      .reset(reset),
      .src_sel(src_r),
      .div_sel(div_r),
      .tk(tk)
   );

   // buzzer modes use only the low six frequency bits
   sgc_tone u_tone (
      .core_clk(core_clk),
      .reset(reset),
      .tick(tk.tick),
      .active(busy),
      .rest(mode_r == sgc_pkg::SGC_MODE_MELODY && snd_r[14]),
      .period(mode_r == sgc_pkg::SGC_MODE_MELODY ? snd_r[7:0] : {2'b00, snd_r[5:0]}),
      .high_len(snd_r[13:8]),
      .wave(wave)
   );

   // direct drive idles both pins low; normal drive keeps a complementary pair
   assign tone_out = wave;
   assign tone_out_n = drive_r ? !wave : (busy && !wave);
   assign irq = (empty_r && ie_r[1]) || (done_r && ie_r[0]);
   assign rdata = rdata_r;

   clk_locked_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr_clk && en_r) |=> $stable(src_r) && $stable(div_r) && $stable(dbg_run_r))
      else $error("clock control changed while enabled");
   irq_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr_inte && wdata[1:0] == 2'b00) |=> !irq)
      else $error("irq raised with enables clear");
   empty_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr_dat && !stop_wr && !tk.tick) |=> !empty_r)
      else $error("buffer write did not clear empty");
   stop_sets_a: assert property (@(posedge core_clk) disable iff (reset)
      stop_wr |=> empty_r)
      else $error("stop write did not set empty");
   done_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr_intf && wdata[0] && !tk.tick) |=> !done_r)
      else $error("done not cleared");
   busy_read_a: assert property (@(posedge core_clk) disable iff (reset)
      (rd && addr == `SGC_OFS_INTF) |=> rdata[8] == $past(busy))
      else $error("busy read wrong");
   stop_end_a: assert property (@(posedge core_clk) disable iff (reset)
      (stop_r && busy && tk.tick && en_r) |=> !busy && done_r)
      else $error("stop did not end output");
   half_write_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr && addr == `SGC_OFS_DAT && !full_word) |=> $stable(buf_r))
      else $error("byte write altered buffer");
endmodule

// *** sim/sgc_buzzer.sv ***
// piezo buzzer stand-in: counts level changes across its two terminals
`timescale 1ns/1ns
module sgc_buzzer (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic pin_a,
   input wire logic pin_b,
   output int edges
);
   logic [1:0] last_r;
   // passive load: it only listens, so it can never hold the pins
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         last_r <= 2'h0;
         edges <= 0;
      end else begin
         last_r <= {pin_a, pin_b};
         if ({pin_a, pin_b} !== last_r) edges <= edges + 1;
      end
   end
endmodule

// *** sim/sgc_top_tb.sv ***
// self-checking bench for the sound generator control block
`timescale 1ns/1ns
module sgc_top_tb;
   logic core_clk, reset, wr, rd, full_word, debug_mode;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, d;
   logic tone_out, tone_out_n, irq;
   int edges, e0;
   int mismatches = 0;
   int checked = 0;
   int m;
   sgc_top u_sgc_top (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .full_word(full_word), .rd(rd), .rdata(rdata), .debug_mode(debug_mode),
      .tone_out(tone_out), .tone_out_n(tone_out_n), .irq(irq));
   sgc_buzzer u_sgc_buzzer (.core_clk(core_clk), .reset(reset), .pin_a(tone_out),
      .pin_b(tone_out_n), .edges(edges));
   task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [15:0] v, input logic fw);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      full_word <= fw;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task rd_chk(input logic [3:0] a, input logic [15:0] exp, input string msg);
      rd_reg(a, d);
      check(d, exp, msg);
   endtask
   // polls in reads of two cycles each, so n covers 2*n cycles
   task wait_reg(input logic [3:0] a, input logic [15:0] exp, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         rd_reg(a, d);
         if (d === exp) break;
      end
      check(d, exp, "wait for register value");
   endtask
   task irq_chk(input logic exp);
      @(posedge core_clk);
      #1 check({15'h0000, irq}, {15'h0000, exp}, "irq level");
   endtask
   task stop_out();
      wr_reg(4'h4, 16'h0101, 1'b1);
      rd_chk(4'h4, 16'h0101, "stop bit while stopping");
      wait_reg(4'h8, 16'h0003, 3000);
      rd_chk(4'h4, 16'h0001, "stop bit after end");
      wr_reg(4'h8, 16'h0001, 1'b1);
   endtask
   task t_reset();
      rd_chk(4'h0, 16'h0000, "clock control reset");
      rd_chk(4'h2, 16'h0000, "select reset");
      rd_chk(4'h4, 16'h0000, "control reset");
      rd_chk(4'h6, 16'h00ff, "buffer reset");
      rd_chk(4'h8, 16'h0002, "flags reset");
      rd_chk(4'ha, 16'h0000, "enables reset");
      rd_chk(4'hc, 16'h0000, "unmapped read");
      check({14'h0000, tone_out, tone_out_n}, 16'h0000, "idle direct drive pins");
      irq_chk(1'b0);
   endtask
   task t_modes();
      for (m = 0; m < 4; m++) begin
         wr_reg(4'h2, 16'h0f04 | 16'(m), 1'b1);
         if (m < 3) rd_chk(4'h2, 16'h0f04 | 16'(m), "select readback");
      end
      rd_chk(4'h2, 16'h0f07, "reserved mode readback");
      check({14'h0000, tone_out, tone_out_n}, 16'h0001, "idle normal drive pins");
      wr_reg(4'h2, 16'h0000, 1'b1);
      rd_chk(4'h2, 16'h0000, "select direct normal");
   endtask
   task t_clock();
      wr_reg(4'h0, 16'h0171, 1'b1);
      rd_chk(4'h0, 16'h0171, "clock control readback");
      wr_reg(4'h4, 16'h0001, 1'b1);
      wr_reg(4'h0, 16'h0000, 1'b1);
      rd_chk(4'h0, 16'h0171, "clock control locked");
      rd_chk(4'h4, 16'h0001, "enable readback");
   endtask
   task t_start();
      wr_reg(4'h6, 16'h1111, 1'b0);
      rd_chk(4'h6, 16'h00ff, "byte write ignored");
      rd_chk(4'h8, 16'h0002, "flags after byte write");
      wr_reg(4'h6, 16'h0204, 1'b1);
      rd_chk(4'h8, 16'h0000, "empty cleared by buffer write");
      wait_reg(4'h8, 16'h0102, 3000);
      e0 = edges;
      repeat (20000) @(posedge core_clk);
      check(16'(edges > e0), 16'h0001, "tone toggles while busy");
   endtask
   task t_irq_stop();
      wr_reg(4'ha, 16'h0002, 1'b1);
      irq_chk(1'b1);
      wr_reg(4'ha, 16'h0001, 1'b1);
      irq_chk(1'b0);
      wr_reg(4'h4, 16'h0101, 1'b1);
      wait_reg(4'h8, 16'h0003, 3000);
      irq_chk(1'b1);
      wr_reg(4'h6, 16'h0204, 1'b1);
      rd_chk(4'h8, 16'h0000, "buffer write clears done");
      irq_chk(1'b0);
      wait_reg(4'h8, 16'h0102, 3000);
      wr_reg(4'h4, 16'h0001, 1'b1);
      rd_chk(4'h4, 16'h0001, "zero stop write no effect");
      stop_out();
      rd_chk(4'h8, 16'h0002, "done write one clears");
      wr_reg(4'ha, 16'h0000, 1'b1);
   endtask
   task t_debug();
      wr_reg(4'h4, 16'h0000, 1'b1);
      wr_reg(4'h0, 16'h0071, 1'b1);
      rd_chk(4'h0, 16'h0071, "clock control while disabled");
      wr_reg(4'h4, 16'h0001, 1'b1);
      debug_mode <= 1'b1;
      wr_reg(4'h6, 16'h0204, 1'b1);
      repeat (5000) @(posedge core_clk);
      rd_chk(4'h8, 16'h0000, "no load during debug halt");
      debug_mode <= 1'b0;
      wait_reg(4'h8, 16'h0102, 3000);
      stop_out();
   endtask
   task t_oneshot_melody();
      wr_reg(4'h2, 16'h0001, 1'b1);
      wr_reg(4'h6, 16'h0204, 1'b1);
      wait_reg(4'h8, 16'h0102, 3000);
      stop_out();
      wr_reg(4'h2, 16'h0002, 1'b1);
      wr_reg(4'h6, 16'h0004, 1'b1);
      wait_reg(4'h8, 16'h0102, 3000);
      wait_reg(4'h8, 16'h0003, 25000);
      wr_reg(4'h2, 16'h0003, 1'b1);
      wr_reg(4'h6, 16'h0204, 1'b1);
      repeat (3200) @(posedge core_clk);
      rd_chk(4'h8, 16'h0000, "reserved mode does not start");
   endtask
   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // about 90k cycles: the full run needs roughly 70k
   initial begin
      #1800000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      full_word = 1'b0;
      debug_mode = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_modes();
      t_clock();
      t_start();
      t_irq_stop();
      t_debug();
      t_oneshot_melody();
      tally_and_finish();
   end
endmodule
